// ===== src/pwp_pkg.sv
// shared constants and types for the protection and status block
package pwp_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 9;
   // memory map
   localparam logic [3:0] A_VWIPER0 = 4'h0;
   localparam logic [3:0] A_VWIPER1 = 4'h1;
   localparam logic [3:0] A_NVWIPER0 = 4'h2;
   localparam logic [3:0] A_NVWIPER1 = 4'h3;
   localparam logic [3:0] A_TERM_A = 4'h4;
   localparam logic [3:0] A_STATUS = 4'h5;
   localparam logic [3:0] A_VWIPER2 = 4'h6;
   localparam logic [3:0] A_VWIPER3 = 4'h7;
   localparam logic [3:0] A_NVWIPER2 = 4'h8;
   localparam logic [3:0] A_NVWIPER3 = 4'h9;
   localparam logic [3:0] A_TERM_B = 4'hA;
   localparam logic [3:0] A_GP_FIRST = 4'hB;
   // protection_status field positions
   localparam int ST_WP = 0;
   localparam int ST_RSVD1 = 1;
   localparam int ST_POT0_LOCK = 2;
   localparam int ST_POT1_LOCK = 3;
   localparam int ST_NV_WRITE_ACTIVE = 4;
   localparam int ST_POT2_LOCK = 5;
   localparam int ST_POT3_LOCK = 6;
   localparam int ST_RSVD_LO = 7;
   localparam int ST_RSVD_HI = 8;
   localparam logic [8:0] STATUS_RESET = 9'h182;
   // terminal control: pot with lower index owns the low nibble
   localparam logic [8:0] TERM_LOW_NIBBLE = 9'h00F;
   localparam logic [8:0] TERM_HIGH_NIBBLE = 9'h0F0;
   localparam logic [8:0] TERM_FULL_MASK = 9'h0FF;
   // factory state
   localparam logic [8:0] NV_WIPER_MID_8BIT = 9'h080;
   localparam logic [8:0] NV_WIPER_MID_7BIT = 9'h040;
   localparam logic [3:0] LOCK_FACTORY = 4'h0;
   localparam logic WP_FACTORY = 1'b0;
   // nonvolatile programming cycle
   localparam int CLK_PERIOD_NS = 40;
   localparam int NV_WRITE_NS = 10000;
   localparam int NV_WRITE_CYC = (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NV_CNT_W = 16;

   typedef enum logic [1:0] {
      PWP_OP_READ = 2'b00,
      PWP_OP_WRITE = 2'b01,
      PWP_OP_INC = 2'b10,
      PWP_OP_DEC = 2'b11
   } pwp_op_t;

   // hidden nonvolatile bit selector: 0..3 pot lock, 4 write protect
   localparam logic [2:0] HV_TGT_WP = 3'h4;
endpackage : pwp_pkg

// ===== src/pwp_sync3.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pwp_sync3 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // pins in, filtered levels out
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] filt;
   } pwp_sync_st_t;

   pwp_sync_st_t st_q;
   pwp_sync_st_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.s1 = pin_in;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      // only the later stages vote, so a metastable first stage never leaks
      for (int i = 0; i < WIDTH; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.filt[i] = st_q.s3[i];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= {INIT, INIT, INIT, INIT};
      end else begin
         st_q <= st_d;
      end
   end

   assign level = st_q.filt;
endmodule : pwp_sync3
`default_nettype wire

// ===== src/pwp_nv_timer.sv
// nonvolatile programming cycle timer
`timescale 1ns/1ps
`default_nettype none
module pwp_nv_timer #(
   parameter int CYCLES = pwp_pkg::NV_WRITE_CYC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // control
   input wire logic start,
   output logic busy,
   output logic done
);
   typedef struct packed {
      logic [pwp_pkg::NV_CNT_W-1:0] cnt;
      logic busy;
      logic done;
   } pwp_tmr_st_t;

   localparam logic [pwp_pkg::NV_CNT_W-1:0] LAST = pwp_pkg::NV_CNT_W'(CYCLES - 1);

   pwp_tmr_st_t st_q;
   pwp_tmr_st_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.done = 1'b0;
      if (st_q.busy) begin
         if (st_q.cnt == LAST) begin
            st_d.busy = 1'b0;
            st_d.done = 1'b1;
            st_d.cnt = '0;
         end else begin
            st_d.cnt = st_q.cnt + 1'b1;
         end
      end else if (start) begin
         st_d.busy = 1'b1;
         st_d.cnt = '0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign busy = st_q.busy;
   assign done = st_q.done;
endmodule : pwp_nv_timer
`default_nettype wire

// ===== src/pwp_protect.sv
// protection, lock and status logic of the quad pot memory map
//
// Contract
// - factory state: mid-scale wipers, protection bits clear
// - five hidden nonvolatile protection bits kept
// - locks and write protect shown in status
// - write protect refuses nonvolatile and general writes
// - protect is pin OR internal bit
// - volatile wipers and terminal control never protected
// - protection bit changes only by high voltage
// - protect pin exists only on potentiometer variant
// - status at 05h, read only
// - status layout with reserved bits reading one
// - pot lock refuses its wiper writes
// - pots 2,3 lock their terminal_ctrl_b nibble
// - pots 0,1 lock their terminal_ctrl_a nibble
// - lock status reloaded from nonvolatile on reset
// - write active flag; only 00,01,04,05 meanwhile
// - status bits not writable, only mirror state
// - nonvolatile access during write cycle is error
// - disallowed command errors until command pin cycled
//
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module pwp_protect #(
   parameter bit HAS_WP_PIN = 1'b1,
   parameter int NV_WRITE_CYCLES = pwp_pkg::NV_WRITE_CYC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // pins from outside the clock domain
   input wire logic write_protect_n,
   input wire logic reset_pin_n,
   input wire logic high_voltage_cmd_pin,
   // decoded serial command
   input wire logic cmd_valid,
   input wire logic [3:0] cmd_addr,
   input wire logic [1:0] cmd_op,
   // high-voltage protection command
   input wire logic hv_qualified,
   input wire logic hv_valid,
   input wire logic [2:0] hv_target,
   input wire logic hv_set,
   // command answer
   output logic resp_valid,
   output logic resp_ok,
   output logic resp_error,
   output logic [8:0] resp_rd_data,
   output logic [8:0] resp_wr_mask,
   output logic nv_write_start,
   // state
   output logic [8:0] protection_status,
   output logic error_state,
   output logic nv_write_active
);
   typedef struct packed {
      logic [3:0] lock_nv;
      logic wp_nv;
      logic [3:0] lock_sh;
      logic err;
      logic hv_pin_prev;
      logic hv_pend;
      logic [2:0] hv_tgt;
      logic hv_val;
      logic start;
      logic resp_valid;
      logic resp_ok;
      logic resp_err;
      logic [8:0] rd_data;
      logic [8:0] wr_mask;
      logic [8:0] status;
   } pwp_st_t;

   pwp_st_t st_q;
   pwp_st_t st_d;

   logic [2:0] pins_lvl;
   logic wp_pin_n;
   logic rstpin_n;
   logic hv_pin_lvl;
   logic tmr_busy;
   logic tmr_done;

   ////////////////////////////////////////////////////////////////////////////
   pwp_sync3 #(
      .WIDTH(3),
      .INIT(3'h7)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin_in({high_voltage_cmd_pin, reset_pin_n, write_protect_n}),
      .level(pins_lvl)
   );

   assign wp_pin_n = pins_lvl[0];
   assign rstpin_n = pins_lvl[1];
   assign hv_pin_lvl = pins_lvl[2];

   pwp_nv_timer #(
      .CYCLES(NV_WRITE_CYCLES)
   ) u_tmr (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .start(st_q.start),
      .busy(tmr_busy),
      .done(tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   logic wp_eff;
   logic [1:0] pot_idx;
   logic is_vwiper;
   logic is_nvwiper;
   logic is_gp;
   logic is_term;
   logic is_status;
   logic is_write;
   logic is_incdec;
   logic busy_any;
   logic [3:0] lock_eff;
   logic bad;
   logic ok;
   logic start_nv;
   logic [8:0] mask;
   logic [8:0] status_d;

   always_comb begin
      wp_eff = st_q.wp_nv | (HAS_WP_PIN & ~wp_pin_n);
      busy_any = tmr_busy | st_q.start;
      // status lags by a cycle, so a bit being cleared refuses until status shows it clear
      lock_eff = st_q.lock_sh | {st_q.status[pwp_pkg::ST_POT3_LOCK],
                                 st_q.status[pwp_pkg::ST_POT2_LOCK],
                                 st_q.status[pwp_pkg::ST_POT1_LOCK],
                                 st_q.status[pwp_pkg::ST_POT0_LOCK]};
      is_vwiper = 1'b0;
      is_nvwiper = 1'b0;
      is_term = 1'b0;
      is_status = 1'b0;
      is_gp = (cmd_addr >= pwp_pkg::A_GP_FIRST);
      pot_idx = 2'd0;
      unique case (cmd_addr)
         pwp_pkg::A_VWIPER0: is_vwiper = 1'b1;
         pwp_pkg::A_VWIPER1: begin
            is_vwiper = 1'b1;
            pot_idx = 2'd1;
         end
         pwp_pkg::A_VWIPER2: begin
            is_vwiper = 1'b1;
            pot_idx = 2'd2;
         end
         pwp_pkg::A_VWIPER3: begin
            is_vwiper = 1'b1;
            pot_idx = 2'd3;
         end
         pwp_pkg::A_NVWIPER0: is_nvwiper = 1'b1;
         pwp_pkg::A_NVWIPER1: begin
            is_nvwiper = 1'b1;
            pot_idx = 2'd1;
         end
         pwp_pkg::A_NVWIPER2: begin
            is_nvwiper = 1'b1;
            pot_idx = 2'd2;
         end
         pwp_pkg::A_NVWIPER3: begin
            is_nvwiper = 1'b1;
            pot_idx = 2'd3;
         end
         pwp_pkg::A_TERM_A: is_term = 1'b1;
         pwp_pkg::A_TERM_B: begin
            is_term = 1'b1;
            pot_idx = 2'd2;
         end
         pwp_pkg::A_STATUS: is_status = 1'b1;
         default: ;
      endcase
      is_write = (cmd_op == pwp_pkg::PWP_OP_WRITE);
      is_incdec = (cmd_op == pwp_pkg::PWP_OP_INC) || (cmd_op == pwp_pkg::PWP_OP_DEC);

      // disallowed op on an address: errors, not a silent refusal
      bad = 1'b0;
      if (is_status && (cmd_op != pwp_pkg::PWP_OP_READ)) begin
         bad = 1'b1;
      end
      if ((is_nvwiper || is_gp || is_term) && is_incdec) begin
         bad = 1'b1;
      end
      // during a programming cycle only the low volatile locations answer
      if (busy_any && !(cmd_addr == pwp_pkg::A_VWIPER0 || cmd_addr == pwp_pkg::A_VWIPER1
                        || cmd_addr == pwp_pkg::A_TERM_A || is_status)) begin
         bad = 1'b1;
      end

      // lock and protect refusals are quiet: no error state
      ok = 1'b1;
      mask = '0;
      start_nv = 1'b0;
      if ((is_vwiper || is_nvwiper) && (is_write || is_incdec)
          && lock_eff[pot_idx]) begin
         ok = 1'b0;
      end
      if ((is_nvwiper || is_gp) && is_write) begin
         if (wp_eff || st_q.status[pwp_pkg::ST_WP]) begin
            ok = 1'b0;
         end else if (ok) begin
            start_nv = 1'b1;
         end
      end
      // volatile writes never look at write protect
      if (is_term && is_write) begin
         mask = pwp_pkg::TERM_FULL_MASK;
         if (lock_eff[pot_idx]) begin
            mask = mask & ~pwp_pkg::TERM_LOW_NIBBLE;
         end
         if (lock_eff[pot_idx + 2'd1]) begin
            mask = mask & ~pwp_pkg::TERM_HIGH_NIBBLE;
         end
      end
      if (!is_write) begin
         mask = '0;
      end

      status_d = pwp_pkg::STATUS_RESET;
      status_d[pwp_pkg::ST_WP] = wp_eff;
      status_d[pwp_pkg::ST_POT0_LOCK] = st_q.lock_sh[0];
      status_d[pwp_pkg::ST_POT1_LOCK] = st_q.lock_sh[1];
      status_d[pwp_pkg::ST_POT2_LOCK] = st_q.lock_sh[2];
      status_d[pwp_pkg::ST_POT3_LOCK] = st_q.lock_sh[3];
      status_d[pwp_pkg::ST_NV_WRITE_ACTIVE] = busy_any;
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_d = st_q;
      st_d.start = 1'b0;
      st_d.resp_valid = 1'b0;
      st_d.resp_ok = 1'b0;
      st_d.resp_err = 1'b0;
      st_d.wr_mask = '0;
      st_d.hv_pin_prev = hv_pin_lvl;
      st_d.status = status_d;

      // a cycle of the command pin to its plain high level ends the error
      if (hv_pin_lvl && !st_q.hv_pin_prev) begin
         st_d.err = 1'b0;
      end

      // commit of a hidden bit when its programming cycle ends
      if (tmr_done && st_q.hv_pend) begin
         st_d.hv_pend = 1'b0;
         if (st_q.hv_tgt == pwp_pkg::HV_TGT_WP) begin
            st_d.wp_nv = st_q.hv_val;
         end else begin
            st_d.lock_nv[st_q.hv_tgt[1:0]] = st_q.hv_val;
            st_d.lock_sh[st_q.hv_tgt[1:0]] = st_q.hv_val;
         end
      end

      if (!rstpin_n) begin
         // serial side is held off; a running program cycle still finishes
         st_d.lock_sh = st_q.lock_nv;
      end else if (hv_valid && !st_q.err) begin
         st_d.resp_valid = 1'b1;
         if (busy_any) begin
            st_d.err = 1'b1;
            st_d.resp_err = 1'b1;
         end else if (hv_qualified && hv_target <= pwp_pkg::HV_TGT_WP) begin
            st_d.hv_pend = 1'b1;
            st_d.hv_tgt = hv_target;
            st_d.hv_val = hv_set;
            st_d.start = 1'b1;
            st_d.resp_ok = 1'b1;
         end
      end else if (cmd_valid && !st_q.err) begin
         st_d.resp_valid = 1'b1;
         st_d.rd_data = status_d;
         if (bad) begin
            st_d.err = 1'b1;
            st_d.resp_err = 1'b1;
         end else begin
            st_d.resp_ok = ok;
            st_d.wr_mask = mask;
            st_d.start = start_nv;
         end
      end else if (cmd_valid || hv_valid) begin
         st_d.resp_valid = 1'b1;
         st_d.resp_err = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
         st_q.lock_nv <= pwp_pkg::LOCK_FACTORY;
         st_q.lock_sh <= pwp_pkg::LOCK_FACTORY;
         st_q.wp_nv <= pwp_pkg::WP_FACTORY;
         st_q.hv_pin_prev <= 1'b1;
         st_q.status <= pwp_pkg::STATUS_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign resp_valid = st_q.resp_valid;
   assign resp_ok = st_q.resp_ok;
   assign resp_error = st_q.resp_err;
   assign resp_rd_data = st_q.rd_data;
   assign resp_wr_mask = st_q.wr_mask;
   assign nv_write_start = st_q.start;
   assign protection_status = st_q.status;
   assign error_state = st_q.err;
   assign nv_write_active = st_q.status[pwp_pkg::ST_NV_WRITE_ACTIVE];
endmodule : pwp_protect
`default_nettype wire

// ===== verification/pwp_protect_props.sv
// concurrent checks on the ports of the protection and status block
`timescale 1ns/1ps
`default_nettype none
module pwp_protect_props #(
   parameter bit HAS_WP_PIN = 1'b1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // pins and requests
   input wire logic write_protect_n,
   input wire logic high_voltage_cmd_pin,
   input wire logic cmd_valid,
   input wire logic [3:0] cmd_addr,
   input wire logic [1:0] cmd_op,
   input wire logic hv_qualified,
   input wire logic hv_valid,
   // answers and state
   input wire logic resp_valid,
   input wire logic resp_ok,
   input wire logic [8:0] resp_wr_mask,
   input wire logic nv_write_start,
   input wire logic [8:0] protection_status,
   input wire logic error_state,
   input wire logic nv_write_active
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic wr;
   assign wr = cmd_valid && !hv_valid && cmd_op == 2'h1;

   AST_RSVD_ONES: assert property (protection_status[8:7] == 2'b11 && protection_status[1])
      else $error("reserved status bits not one");
   AST_RESP_CAUSE: assert property (resp_valid |-> $past(cmd_valid || hv_valid))
      else $error("answer without a request");
   AST_STATUS_RO: assert property (cmd_valid && !hv_valid && cmd_addr == 4'h5 && cmd_op != 2'h0
      |=> !resp_ok) else $error("status register accepted a change");
   AST_WP_REFUSE: assert property (wr && protection_status[0]
      && (cmd_addr inside {4'h2, 4'h3, 4'h8, 4'h9} || cmd_addr >= 4'hB) |=> !resp_ok)
      else $error("protected write accepted");
   AST_WP_PIN: assert property ((!write_protect_n && HAS_WP_PIN) [*8] |-> protection_status[0])
      else $error("protect pin not shown in status");
   AST_LOCK_REFUSE: assert property (wr && cmd_addr == 4'h0 && protection_status[2] |=> !resp_ok)
      else $error("locked wiper write accepted");
   AST_MASK_A: assert property (wr && cmd_addr == 4'h4 && protection_status[2]
      |=> resp_wr_mask[3:0] == 4'h0) else $error("locked nibble writable in first control");
   AST_MASK_B: assert property (wr && cmd_addr == 4'hA && protection_status[6]
      |=> resp_wr_mask[7:4] == 4'h0) else $error("locked nibble writable in second control");
   AST_START_ACTIVE: assert property (nv_write_start |=> nv_write_active)
      else $error("programming start without active flag");
   AST_ACTIVE_HOLD: assert property ($rose(nv_write_active) |-> nv_write_active [*4])
      else $error("active flag dropped too early");
   AST_HV_UNQUAL: assert property (hv_valid && !hv_qualified |=> !resp_ok)
      else $error("unqualified protection command accepted");
   AST_ERR_HOLD: assert property (error_state && !high_voltage_cmd_pin |=> error_state)
      else $error("error left without command pin rise");
endmodule : pwp_protect_props
bind pwp_protect pwp_protect_props #(.HAS_WP_PIN(HAS_WP_PIN)) u_props (
   .clk_sys(clk_sys), .rst_n(rst_n), .write_protect_n(write_protect_n),
   .high_voltage_cmd_pin(high_voltage_cmd_pin), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
   .cmd_op(cmd_op), .hv_qualified(hv_qualified), .hv_valid(hv_valid), .resp_valid(resp_valid),
   .resp_ok(resp_ok), .resp_wr_mask(resp_wr_mask), .nv_write_start(nv_write_start),
   .protection_status(protection_status), .error_state(error_state),
   .nv_write_active(nv_write_active));
`default_nettype wire

// ===== verification/pwp_host.sv
// host model issuing serial and high-voltage commands
`timescale 1ns/1ps
`default_nettype none
module pwp_host (
   // clock
   input wire logic clk_sys,
   // command pins
   output var logic high_voltage_cmd_pin,
   output var logic cmd_valid,
   output var logic [3:0] cmd_addr,
   output var logic [1:0] cmd_op,
   output var logic hv_qualified,
   output var logic hv_valid,
   output var logic [2:0] hv_target,
   output var logic hv_set,
   // answer
   input wire logic resp_valid,
   input wire logic resp_ok,
   input wire logic resp_error,
   input wire logic [8:0] resp_rd_data,
   input wire logic [8:0] resp_wr_mask,
   input wire logic nv_write_start
);
   logic r_valid, r_ok, r_err, r_start;
   logic [8:0] r_data, r_mask;
   initial begin
      high_voltage_cmd_pin = 1'b1;
      cmd_valid = 1'b0;
      cmd_addr = 4'h0;
      cmd_op = 2'h0;
      hv_qualified = 1'b0;
      hv_valid = 1'b0;
      hv_target = 3'h0;
      hv_set = 1'b0;
   end
   // answer stands one cycle only, so it is taken just after the edge that launched it
   task automatic grab();
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      hv_valid <= 1'b0;
      #1;
      r_valid = resp_valid;
      r_ok = resp_ok;
      r_err = resp_error;
      r_start = nv_write_start;
      r_data = resp_rd_data;
      r_mask = resp_wr_mask;
   endtask : grab
   task automatic cmd(input logic [3:0] a, input logic [1:0] op);
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_addr <= a;
      cmd_op <= op;
      grab();
   endtask : cmd
   // protection bits are only ever changed through this path
   task automatic hv(input logic [2:0] t, input logic s, input logic q);
      @(posedge clk_sys);
      hv_valid <= 1'b1;
      hv_target <= t;
      hv_set <= s;
      hv_qualified <= q;
      grab();
   endtask : hv
   task automatic poll();
      int n;
      n = 0;
      r_data = 9'h010;
      while (r_data[4] !== 1'b0 && n < 50) begin
         cmd(4'h5, 2'h0);
         n++;
      end
      cmd(4'h5, 2'h0);
   endtask : poll
   task automatic clr_err();
      @(posedge clk_sys);
      high_voltage_cmd_pin <= 1'b0;
      repeat (8) @(posedge clk_sys);
      high_voltage_cmd_pin <= 1'b1;
      repeat (8) @(posedge clk_sys);
   endtask : clr_err
endmodule : pwp_host
`default_nettype wire

// ===== verification/nv_write_protect_lock_status_tb.sv
// self-checking bench for the protection and status block
`timescale 1ns/1ps
`default_nettype none
`define check_eq(name, exp, got) begin check_count++; if ((got) !== (exp)) begin \
   miscompares++; $display("mismatch %s expected %h seen %h", name, exp, got); end end
module nv_write_protect_lock_status_tb;
   localparam logic [3:0] WIPER_A [4] = '{4'h0, 4'h3, 4'h6, 4'h9};
   localparam int LOCK_POS [4] = '{2, 3, 5, 6};
   logic clk_sys, rst_n, write_protect_n, reset_pin_n, high_voltage_cmd_pin;
   logic cmd_valid, hv_qualified, hv_valid, hv_set, resp_valid, resp_ok, resp_error;
   logic nv_write_start, error_state, nv_write_active;
   logic [3:0] cmd_addr;
   logic [1:0] cmd_op;
   logic [2:0] hv_target;
   logic [8:0] resp_rd_data, resp_wr_mask, protection_status, exp_st;
   int miscompares = 0;
   int check_count = 0;
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   pwp_protect #(.HAS_WP_PIN(1'b1), .NV_WRITE_CYCLES(5)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .write_protect_n(write_protect_n), .reset_pin_n(reset_pin_n),
      .high_voltage_cmd_pin(high_voltage_cmd_pin), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
      .cmd_op(cmd_op), .hv_qualified(hv_qualified), .hv_valid(hv_valid), .hv_target(hv_target),
      .hv_set(hv_set), .resp_valid(resp_valid), .resp_ok(resp_ok), .resp_error(resp_error),
      .resp_rd_data(resp_rd_data), .resp_wr_mask(resp_wr_mask), .nv_write_start(nv_write_start),
      .protection_status(protection_status), .error_state(error_state),
      .nv_write_active(nv_write_active));
   pwp_host host (.clk_sys(clk_sys), .high_voltage_cmd_pin(high_voltage_cmd_pin),
      .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_op(cmd_op), .hv_qualified(hv_qualified),
      .hv_valid(hv_valid), .hv_target(hv_target), .hv_set(hv_set), .resp_valid(resp_valid),
      .resp_ok(resp_ok), .resp_error(resp_error), .resp_rd_data(resp_rd_data),
      .resp_wr_mask(resp_wr_mask), .nv_write_start(nv_write_start));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   initial begin : watchdog
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      finish_test();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin : main
      rst_n = 1'b0;
      write_protect_n = 1'b1;
      reset_pin_n = 1'b1;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      `check_eq("status", 9'h182, protection_status)
      host.cmd(4'h5, 2'h0);
      `check_eq("rd_status", 9'h182, host.r_data)
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         host.cmd((i < 3) ? 4'h5 : 4'h2, (i < 3) ? 2'(i + 1) : 2'h2);
         `check_eq("bad_cmd_err", 1'b1, host.r_err)
         host.cmd(4'h0, 2'h0);
         `check_eq("err_ignore", 1'b1, host.r_err)
         host.clr_err();
         `check_eq("err_clear", 1'b0, error_state)
      end
      $display("test error done");
      host.hv(3'h4, 1'b1, 1'b0);
      `check_eq("hv_unqual", 1'b0, host.r_ok)
      host.poll();
      `check_eq("wp_kept", 9'h182, host.r_data)
      host.cmd(4'h4, 2'h1);
      `check_eq("mask_free", 9'h0FF, host.r_mask)
      exp_st = 9'h182;
      for (int i = 0; i < 4; i++) begin
         host.hv(3'(i), 1'b1, 1'b1);
         `check_eq("hv_start", 1'b1, host.r_start)
         host.poll();
         exp_st[LOCK_POS[i]] = 1'b1;
         `check_eq("lock_status", exp_st, host.r_data)
         host.cmd(WIPER_A[i], 2'h1);
         `check_eq("locked_wiper", 1'b0, host.r_ok)
         host.cmd((i < 2) ? 4'h4 : 4'hA, 2'h1);
         `check_eq("term_mask", (i % 2 == 0) ? 9'h0F0 : 9'h000, host.r_mask)
      end
      $display("test lock done");
      host.hv(3'h4, 1'b1, 1'b1);
      host.poll();
      `check_eq("wp_set", exp_st | 9'h001, host.r_data)
      host.cmd(4'hB, 2'h1);
      `check_eq("wp_refuse", 2'b00, {host.r_ok, host.r_err})
      host.cmd(4'h4, 2'h1);
      `check_eq("wp_volatile", 1'b1, host.r_ok)
      host.hv(3'h4, 1'b0, 1'b1);
      host.poll();
      `check_eq("wp_clear", exp_st, host.r_data)
      @(posedge clk_sys);
      write_protect_n <= 1'b0;
      repeat (10) @(posedge clk_sys);
      host.cmd(4'hB, 2'h1);
      `check_eq("pin_refuse", 1'b0, host.r_ok)
      `check_eq("pin_status", 1'b1, host.r_data[0])
      @(posedge clk_sys);
      write_protect_n <= 1'b1;
      repeat (10) @(posedge clk_sys);
      $display("test protect done");
      host.cmd(4'hB, 2'h1);
      `check_eq("gp_write", 2'b11, {host.r_ok, host.r_start})
      host.cmd(4'h4, 2'h1);
      `check_eq("busy_allowed", 2'b11, {host.r_ok, host.r_data[4]})
      `check_eq("active_out", 1'b1, nv_write_active)
      host.cmd(4'hC, 2'h0);
      `check_eq("busy_error", 1'b1, host.r_err)
      host.clr_err();
      host.poll();
      `check_eq("busy_over", exp_st, host.r_data)
      `check_eq("idle_out", 1'b0, nv_write_active)
      $display("test active done");
      @(posedge clk_sys);
      reset_pin_n <= 1'b0;
      repeat (6) @(posedge clk_sys);
      host.cmd(4'h5, 2'h0);
      `check_eq("rst_silent", 1'b0, host.r_valid)
      @(posedge clk_sys);
      reset_pin_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      host.cmd(4'h5, 2'h0);
      `check_eq("rst_reload", exp_st, host.r_data)
      `check_eq("status_out", exp_st, protection_status)
      $display("test reset pin done");
      finish_test();
   end
endmodule : nv_write_protect_lock_status_tb
`default_nettype wire
